// ---- pkg/sfpm_params.svh ----
// constants of the serial flash pin and bus-mode front end
// assumes inclusion by both link ends and by the package
`ifndef SFPM_PARAMS_SVH
`define SFPM_PARAMS_SVH

`define SFPM_BYTE_W    8
`define SFPM_LINE_N    4
`define SFPM_CNT_W     3
`define SFPM_STEP_SDR  3'h1
`define SFPM_STEP_QUAD 3'h4
`define SFPM_CNT_ZERO  3'h0
`define SFPM_OE_OFF    4'hf
`define SFPM_OE_QUAD   4'h0
`define SFPM_OE_SDR_H  4'h2
`define SFPM_OE_SDR_D  4'hd
`define SFPM_DIV_W     8
`define SFPM_HALF_DEF  8'h04

`endif

// ---- pkg/sfpm_pkg.sv ----
// types shared by the host end and the device end of the flash link
// assumes sfpm_params.svh on the include path
`include "sfpm_params.svh"
package sfpm_pkg;
   typedef logic [`SFPM_BYTE_W-1:0] sfpm_byte_t;
   typedef logic [`SFPM_LINE_N-1:0] sfpm_lines_t;
   typedef logic [`SFPM_CNT_W-1:0]  sfpm_cnt_t;

   typedef enum logic {
      SFPM_IDLE = 1'b0,
      SFPM_RUN  = 1'b1
   } sfpm_hst_st_t;

   // device: cleared while deselected
   typedef struct packed {
      sfpm_cnt_t  cnt;
      sfpm_byte_t sh;
   } sfpm_lnk_t;

   // device: kept across frames, cleared by the reset pin only
   typedef struct packed {
      logic       qe1;
      logic       qe;
      logic       fl1;
      logic       fl;
      logic       dr1;
      logic       dr;
      sfpm_byte_t rx;
      logic       tgl;
   } sfpm_keep_t;

   // device: falling-edge output stage
   typedef struct packed {
      sfpm_byte_t  tsh;
      sfpm_lines_t o;
      sfpm_lines_t oe_n;
   } sfpm_drv_t;

   // device: core clock side
   typedef struct packed {
      logic       rs1;
      logic       rs;
      logic       t1;
      logic       t2;
      logic       t3;
      sfpm_byte_t rx;
      logic       valid;
      logic       inrst;
      logic       abort;
   } sfpm_core_t;

   // host: all state
   typedef struct packed {
      sfpm_hst_st_t          st;
      logic [`SFPM_DIV_W-1:0] div;
      logic                  sck;
      logic                  cs_n;
      logic                  rstn;
      logic                  fin;
      sfpm_cnt_t             cnt;
      logic                  quad;
      logic                  read;
      logic                  mode3;
      logic                  last;
      logic                  hold;
      sfpm_byte_t            tx;
      sfpm_byte_t            rx;
      sfpm_lines_t           s1;
      sfpm_lines_t           s2;
      sfpm_lines_t           o;
      sfpm_lines_t           oe_n;
      sfpm_byte_t            rx_out;
      logic                  valid;
      logic                  busy;
   } sfpm_hst_t;
endpackage : sfpm_pkg

// ---- pkg/sfpm_if.sv ----
// link wires between the bus master and the flash front end
// assumes idle lines float high through pull-ups
`timescale 1ns/1ps
interface sfpm_if;
   logic        sck;
   logic        cs_n;
   logic        reset_n;
   logic [3:0]  h_o;
   logic [3:0]  h_oe_n;
   logic [3:0]  d_o;
   logic [3:0]  d_oe_n;
   logic [3:0]  io;

   // resolved level of data lines 0..3, pulled high when nobody drives
   assign io = (~h_oe_n & h_o) | (~d_oe_n & d_o) | (h_oe_n & d_oe_n);

   modport host (output sck, cs_n, reset_n, h_o, h_oe_n, input io);
   modport dev  (input sck, cs_n, reset_n, io, output d_o, d_oe_n);
endinterface : sfpm_if

// ---- verilog/sfpm_dev.sv ----
// device end of the flash link: pin roles, pause, reset pin, clock modes
// assumes the link clock comes from the master; core logic runs on i_clk
`timescale 1ns/1ps
`include "sfpm_params.svh"

module sfpm_dev (
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   sfpm_if.dev                  bus,
   input  wire logic            i_quad_enable,
   input  wire logic            i_four_line_command_mode,
   input  wire logic            i_drive,
   input  wire sfpm_pkg::sfpm_byte_t i_tx_byte,
   input  wire logic            i_internal_busy,
   output sfpm_pkg::sfpm_byte_t o_rx_byte,
   output logic                 o_rx_valid,
   output logic                 o_in_reset,
   output logic                 o_op_aborted
);
   import sfpm_pkg::*;

   sfpm_lnk_t   lnk_r;
   sfpm_lnk_t   lnk_nxt;
   sfpm_keep_t  keep_r;
   sfpm_keep_t  keep_nxt;
   sfpm_drv_t   drv_r;
   sfpm_drv_t   drv_nxt;
   sfpm_core_t  core_r;
   sfpm_core_t  core_nxt;
   logic        pin_rst;
   logic        link_clr;
   logic        hold_pin;
   logic        paused;
   logic        quad;
   sfpm_cnt_t   step;
   sfpm_byte_t  word;
   sfpm_byte_t  sel;

   assign pin_rst  = ~bus.reset_n;
   assign link_clr = bus.cs_n | pin_rst;
   assign hold_pin = ~keep_r.qe & ~keep_r.fl;
   assign paused   = hold_pin & ~bus.io[3] & ~bus.cs_n;
   assign quad     = keep_r.fl;
   assign step     = quad ? `SFPM_STEP_QUAD : `SFPM_STEP_SDR;

   // rising edge: mode sync and input shift
   always_comb begin
      lnk_nxt      = lnk_r;
      keep_nxt     = keep_r;
      keep_nxt.qe1 = i_quad_enable;
      keep_nxt.qe  = keep_r.qe1;
      keep_nxt.fl1 = i_four_line_command_mode;
      keep_nxt.fl  = keep_r.fl1;
      keep_nxt.dr1 = i_drive;
      keep_nxt.dr  = keep_r.dr1;
      if (!paused) begin
         if (quad) begin
            lnk_nxt.sh = {lnk_r.sh[3:0], bus.io};
         end else begin
            lnk_nxt.sh = {lnk_r.sh[6:0], bus.io[0]};
         end
         lnk_nxt.cnt = lnk_r.cnt + step;
         if (lnk_nxt.cnt == `SFPM_CNT_ZERO) begin
            keep_nxt.rx  = lnk_nxt.sh;
            keep_nxt.tgl = ~keep_r.tgl;
         end
      end
   end

   // both clock modes: only edges while selected count
   always_ff @(posedge bus.sck or posedge link_clr) begin
      if (link_clr) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   always_ff @(posedge bus.sck or posedge pin_rst) begin
      if (pin_rst) begin
         keep_r <= '0;
      end else begin
         keep_r <= keep_nxt;
      end
   end

   // falling edge: launch the bit or nibble at the current position
   always_comb begin
      drv_nxt = drv_r;
      word    = (lnk_r.cnt == `SFPM_CNT_ZERO) ? i_tx_byte : drv_r.tsh;
      sel     = word << lnk_r.cnt;
      if (!paused) begin
         drv_nxt.tsh = word;
         if (quad) begin
            drv_nxt.o = sel[7:4];
         end else begin
            drv_nxt.o = {2'h0, sel[7], 1'h0};
         end
         if (!keep_r.dr) begin
            drv_nxt.oe_n = `SFPM_OE_OFF;
         end else if (quad) begin
            drv_nxt.oe_n = `SFPM_OE_QUAD;
         end else begin
            drv_nxt.oe_n = `SFPM_OE_SDR_D;
         end
      end
   end

   // deselect or reset pin release every output at once; pause gates the enables below
   // so that the byte in flight survives the pause
   always_ff @(negedge bus.sck or posedge link_clr) begin
      if (link_clr) begin
         drv_r <= '{tsh: '0, o: '0, oe_n: `SFPM_OE_OFF};
      end else begin
         drv_r <= drv_nxt;
      end
   end

   assign bus.d_o    = drv_r.o;
   // pause only releases lines 0..2, so line 3 never feeds back into it
   assign bus.d_oe_n = {drv_r.oe_n[3], drv_r.oe_n[2:0] | {3{paused}}};

   // core side: reset pin sync, byte event crossing, abort detect
   always_comb begin
      core_nxt       = core_r;
      core_nxt.rs1   = bus.reset_n;
      core_nxt.rs    = core_r.rs1;
      core_nxt.t1    = keep_r.tgl;
      core_nxt.t2    = core_r.t1;
      core_nxt.t3    = core_r.t2;
      core_nxt.valid = core_r.t2 ^ core_r.t3;
      if (core_r.t2 ^ core_r.t3) begin
         core_nxt.rx = keep_r.rx;
      end
      core_nxt.inrst = ~core_r.rs;
      core_nxt.abort = ~core_r.rs & ~core_r.inrst & i_internal_busy;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         core_r <= '0;
      end else begin
         core_r <= core_nxt;
      end
   end

   assign o_rx_byte    = core_r.rx;
   assign o_rx_valid   = core_r.valid;
   assign o_in_reset   = core_r.inrst;
   assign o_op_aborted = core_r.abort;
endmodule : sfpm_dev

// ---- verilog/sfpm_host.sv ----
// master end of the flash link: clock divider, chip select, pause, reset pin
// assumes one byte request at a time on i_clk; link clock made here
`timescale 1ns/1ps
`include "sfpm_params.svh"

module sfpm_host #(
   parameter logic [`SFPM_DIV_W-1:0] HALF = `SFPM_HALF_DEF
) (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst,
   sfpm_if.host                      bus,
   input  wire logic                 i_start,
   input  wire sfpm_pkg::sfpm_byte_t i_tx_byte,
   input  wire logic                 i_last,
   input  wire logic                 i_mode3,
   input  wire logic                 i_quad,
   input  wire logic                 i_read,
   input  wire logic                 i_hold,
   input  wire logic                 i_reset_req,
   output logic                      o_busy,
   output sfpm_pkg::sfpm_byte_t      o_rx_byte,
   output logic                      o_rx_valid
);
   import sfpm_pkg::*;

   sfpm_hst_t r;
   sfpm_hst_t h;
   sfpm_cnt_t step;
   sfpm_cnt_t nc;

   assign step = r.quad ? `SFPM_STEP_QUAD : `SFPM_STEP_SDR;

   always_comb begin
      h       = r;
      nc      = r.cnt + step;
      h.s1    = bus.io;
      h.s2    = r.s1;
      h.valid = 1'b0;
      h.rstn  = ~i_reset_req;
      h.hold  = i_hold & ~r.quad;
      if (r.st == SFPM_IDLE) begin
         if (r.cs_n) begin
            h.sck = i_mode3;
         end
         if (i_start) begin
            h.st    = SFPM_RUN;
            h.busy  = 1'b1;
            h.cs_n  = 1'b0;
            h.tx    = i_tx_byte;
            h.quad  = i_quad;
            h.read  = i_read;
            h.last  = i_last;
            h.mode3 = i_mode3;
            h.cnt   = `SFPM_CNT_ZERO;
            h.fin   = 1'b0;
            h.div   = '0;
         end
      end else if (!r.hold) begin
         if (r.div == HALF - 1'b1) begin
            h.div = '0;
            if (!r.sck) begin
               h.sck = 1'b1;
               h.cnt = nc;
               if (r.quad) begin
                  h.rx = {r.rx[3:0], r.s2};
               end else begin
                  h.rx = {r.rx[6:0], r.s2[1]};
               end
               if (nc == `SFPM_CNT_ZERO) begin
                  h.rx_out = h.rx;
                  h.valid  = 1'b1;
                  if (r.mode3) begin
                     h.st   = SFPM_IDLE;
                     h.busy = 1'b0;
                     h.cs_n = r.last;
                  end else begin
                     h.fin = 1'b1;
                  end
               end
            end else begin
               h.sck = 1'b0;
               if (r.fin) begin
                  h.st   = SFPM_IDLE;
                  h.busy = 1'b0;
                  h.cs_n = r.last;
               end else if (r.cnt != `SFPM_CNT_ZERO) begin
                  h.tx = r.tx << step;
               end
            end
         end else begin
            h.div = r.div + 1'b1;
         end
      end
      if (h.quad) begin
         h.o    = h.tx[7:4];
         h.oe_n = h.read ? `SFPM_OE_OFF : `SFPM_OE_QUAD;
      end else begin
         h.o    = {~h.hold, 1'b1, 1'b0, h.tx[7]};
         h.oe_n = `SFPM_OE_SDR_H;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         r      <= '0;
         r.cs_n <= 1'b1;
         r.oe_n <= `SFPM_OE_OFF;
      end else begin
         r <= h;
      end
   end

   assign bus.sck     = r.sck;
   assign bus.cs_n    = r.cs_n;
   assign bus.reset_n = r.rstn;
   assign bus.h_o     = r.o;
   assign bus.h_oe_n  = r.oe_n;
   assign o_busy      = r.busy;
   assign o_rx_byte   = r.rx_out;
   assign o_rx_valid  = r.valid;
endmodule : sfpm_host

// ---- tb/sfpm_monitor.sv ----
// link wire checker
// assumes sfpm_if signals and the bench core reset
`timescale 1ns/1ps
module sfpm_monitor (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_quad_enable,
   input wire logic       i_four_line_command_mode,
   input wire logic       sck,
   input wire logic       cs_n,
   input wire logic       reset_n,
   input wire logic [3:0] h_oe_n,
   input wire logic [3:0] d_o,
   input wire logic [3:0] d_oe_n,
   input wire logic [3:0] io
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   desel_off_a: assert property (cs_n |-> d_oe_n == 4'hf)
      else $error("drive while deselected");
   rst_off_a: assert property (!reset_n |-> d_oe_n == 4'hf)
      else $error("drive in reset");
   pause_off_a: assert property (!cs_n && !io[3] && $past(!io[3])
      && !(i_quad_enable | i_four_line_command_mode) |-> d_oe_n[1]) else $error("drive in pause");
   out_fall_a: assert property (!$stable(d_o) && !cs_n && reset_n |-> !sck)
      else $error("output moved with clock high");
   lane0_fl_a: assert property (!d_oe_n[0] |-> i_four_line_command_mode)
      else $error("line 0 driven in single mode");
   oe_set_a: assert property (d_oe_n inside {4'hf, 4'hd, 4'h0})
      else $error("odd enable set");
   no_clash_a: assert property ((~h_oe_n & ~d_oe_n) == 4'h0)
      else $error("both ends drive a line");
   sck_pause_a: assert property (!cs_n && !h_oe_n[3] && !io[3] && $past(!io[3])
      && !i_four_line_command_mode |-> $stable(sck)) else $error("clock moved in pause");
endmodule : sfpm_monitor

// ---- tb/sfpm_bench.sv ----
// bench joining host and device ends
// assumes sfpm_pkg and sfpm_if compiled first
`timescale 1ns/1ps
module sfpm_bench;
   import sfpm_pkg::*;
   logic       i_clk, i_rst, start, mode3, quad, rd, hold, rreq, lst;
   logic       qe, fl, ibusy, h_busy, h_v, d_v, d_inrst, d_abort;
   sfpm_byte_t tx, h_rx, d_rx, wire_sh, got;
   int         miscompares, checks_done, n_abort;
   sfpm_if bus ();
   sfpm_host #(.HALF(8'h04)) u_sfpm_host (.i_clk(i_clk), .i_rst(i_rst), .bus(bus),
      .i_start(start), .i_tx_byte(tx), .i_last(lst), .i_mode3(mode3), .i_quad(quad),
      .i_read(rd), .i_hold(hold), .i_reset_req(rreq), .o_busy(h_busy), .o_rx_byte(h_rx),
      .o_rx_valid(h_v));
   sfpm_dev u_sfpm_dev (.i_clk(i_clk), .i_rst(i_rst), .bus(bus), .i_quad_enable(qe),
      .i_four_line_command_mode(fl), .i_drive(rd), .i_tx_byte(tx), .i_internal_busy(ibusy),
      .o_rx_byte(d_rx), .o_rx_valid(d_v), .o_in_reset(d_inrst), .o_op_aborted(d_abort));
   sfpm_monitor u_sfpm_monitor (.i_clk(i_clk), .i_rst(i_rst), .i_quad_enable(qe),
      .i_four_line_command_mode(fl), .sck(bus.sck), .cs_n(bus.cs_n), .reset_n(bus.reset_n),
      .h_oe_n(bus.h_oe_n), .d_o(bus.d_o), .d_oe_n(bus.d_oe_n), .io(bus.io));

   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   always @(posedge bus.sck) begin
      if (bus.cs_n === 1'b0) wire_sh <= {wire_sh[6:0], bus.io[0]};
   end

   always @(posedge i_clk) begin
      if (d_abort === 1'b1) n_abort <= n_abort + 1;
   end

   task automatic chk(input sfpm_byte_t seen, input sfpm_byte_t exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop

   // one byte; hp is the cycle at which a 40-cycle pause starts, -1 for none
   // l high raises chip select after the byte; device output starts after the second rising link clock edge that samples i_drive
   task automatic xfer(input sfpm_byte_t t, input logic m3, q, r, input int hp, input logic l);
      int n;
      got = 'x;
      @(posedge i_clk);
      tx <= t;
      lst <= l;
      mode3 <= m3;
      quad <= q;
      rd <= r;
      @(posedge i_clk);
      start <= 1'b1;
      @(posedge i_clk);
      start <= 1'b0;
      for (n = 0; n < 3000; n++) begin
         @(posedge i_clk);
         if (n == hp) hold <= 1'b1;
         if (n == hp + 40) hold <= 1'b0;
         if (h_v === 1'b1) got = h_rx;
         if (n > 2 && h_busy === 1'b0) break;
      end
      if (n == 3000) begin
         miscompares++;
         report_and_stop();
      end
      repeat (8) @(posedge i_clk);
   endtask : xfer

   initial begin
      {start, mode3, quad, rd, hold, rreq, qe, fl, ibusy, lst} = '0;
      {miscompares, checks_done, n_abort} = '0;
      tx = 8'h00;
      i_rst = 1'b1;
      repeat (16) @(posedge i_clk);
      chk({7'h00, bus.reset_n}, 8'h00);
      chk({4'h0, bus.d_oe_n}, 8'h0f);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_clk);
      chk({7'h00, d_inrst}, 8'h00);
      xfer(8'ha5, 1'b0, 1'b0, 1'b0, -1, 1'b1);
      chk(wire_sh, 8'ha5);
      chk(d_rx, 8'ha5);
      chk({7'h00, bus.sck}, 8'h00);
      xfer(8'h3c, 1'b0, 1'b0, 1'b1, -1, 1'b0);
      xfer(8'h3c, 1'b0, 1'b0, 1'b1, -1, 1'b1);
      chk(got, 8'h3c);
      xfer(8'h96, 1'b1, 1'b0, 1'b0, -1, 1'b1);
      chk(d_rx, 8'h96);
      chk({7'h00, bus.sck}, 8'h01);
      xfer(8'hc3, 1'b0, 1'b0, 1'b1, -1, 1'b0);
      xfer(8'hc3, 1'b0, 1'b0, 1'b1, 20, 1'b1);
      chk(got, 8'hc3);
      xfer(8'h5a, 1'b1, 1'b0, 1'b0, 20, 1'b1);
      chk(d_rx, 8'h5a);
      qe <= 1'b1;
      fl <= 1'b1;
      ibusy <= 1'b1;
      rreq <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk({7'h00, d_inrst}, 8'h01);
      chk(n_abort[7:0], 8'h01);
      rreq <= 1'b0;
      ibusy <= 1'b0;
      repeat (8) @(posedge i_clk);
      chk({7'h00, d_inrst}, 8'h00);
      // first frame after the reset pin lets the mode syncs settle
      xfer(8'h00, 1'b0, 1'b0, 1'b0, -1, 1'b1);
      xfer(8'h69, 1'b0, 1'b1, 1'b0, -1, 1'b1);
      chk(d_rx, 8'h69);
      xfer(8'he1, 1'b0, 1'b1, 1'b1, -1, 1'b0);
      xfer(8'he1, 1'b0, 1'b1, 1'b1, -1, 1'b1);
      chk(got, 8'he1);
      report_and_stop();
   end
endmodule : sfpm_bench
